// ---- hw/power_manager_status_irq_regs.sv ----
/*
 * status, interrupt mask/pending and reset-cause registers of the
 * power manager, with the peripheral power control register and the
 * unlock protection that guards it.
 * assumes a simple peripheral bus on ref_clk, a clock generator on the
 * same clock, and detector/reset-source levels from other domains.
 */
`timescale 1ns/100ps

module power_manager_status_irq_regs (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic busSel,
   input wire logic busWrite,
   input wire logic [pm_regs_pkg::ADDR_W-1:0] busAddr,
   input wire logic [pm_regs_pkg::DATA_W-1:0] busWdata,
   output logic [pm_regs_pkg::DATA_W-1:0] busRdata,
   output logic busReady,
   input wire logic clockSelectWritten,
   input wire logic clocksAtNewRate,
   input wire logic mainClockFailDetect,
   input wire logic corePowerOnDetector,
   input wire logic regulatorPowerOnDetector,
   input wire logic regulatorInputMonitor,
   input wire logic brownoutDetect,
   input wire logic externalPinReset,
   input wire logic watchdogReset,
   input wire logic shutdownWakeReset,
   input wire logic debugRequestReset,
   input wire logic jtagReset,
   input wire logic singlePinDebugReset,
   output logic interruptRequest,
   output logic useInternalSystemRcOsc,
   output logic resetPinTestMode,
   output logic forceSlowRcOutput,
   output logic resetPinPullupOn,
   output logic touchRequestClockGate,
   output logic comparatorRequestClockGate,
   output logic adcRequestClockGate,
   output logic asyncTimerRequestClockGate,
   output logic twowireSlave0RequestClockGate,
   output logic twowireSlave1RequestClockGate
);
   import pm_regs_pkg::*;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------

   // true when a bus write in this cycle targets the given offset
   function automatic logic writeTo(input logic sel, input logic wr,
         input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
      writeTo = sel && wr && (addr == off);
   endfunction

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [NUM_ASYNC-1:0] asyncIn;
   logic [NUM_ASYNC-1:0] syncS1_q;
   logic [NUM_ASYNC-1:0] syncS2_q;
   logic [NUM_ASYNC-1:0] syncS3_q;
   logic [NUM_ASYNC-1:0] stable_q;
   logic wrPpc;
   logic wrUnlock;
   logic wrIenw;
   logic wrIdisw;
   logic wrIclr;
   logic unlockArmed_q;
   logic [ADDR_W-1:0] unlockAddr_q;
   logic protectedOk;
   logic accessError;
   logic [PPC_W-1:0] ppc_q;
   logic accErr_q;
   logic settled_q;
   logic clkFail_q;
   logic [DATA_W-1:0] status;
   logic [DATA_W-1:0] statusPrev_q;
   logic [DATA_W-1:0] mask_q;
   logic [DATA_W-1:0] pend_q;
   logic [DATA_W-1:0] rstSrc_q;
   logic [2:0] captureCnt_q;
   logic captured_q;
   logic [DATA_W-1:0] rstOneHot;
   logic [DATA_W-1:0] readMux;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------

   // gather the levels that come from other domains
   assign asyncIn = {singlePinDebugReset, jtagReset, debugRequestReset,
      shutdownWakeReset, watchdogReset, externalPinReset, brownoutDetect,
      regulatorInputMonitor, regulatorPowerOnDetector,
      corePowerOnDetector, mainClockFailDetect};

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         syncS1_q <= '0;
         syncS2_q <= '0;
         syncS3_q <= '0;
      end else begin
         syncS1_q <= asyncIn;
         syncS2_q <= syncS1_q;
         syncS3_q <= syncS2_q;
      end
   end

   // filtered level per input, updated only on agreement
   generate
      for (genvar i = 0; i < NUM_ASYNC; i++) begin : g_filter
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               stable_q[i] <= 1'b0;
            end else if (syncS2_q[i] == syncS3_q[i]) begin
               stable_q[i] <= syncS3_q[i];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // bus decode and unlock protection
   // ---------------------------------------------------------------
   assign wrPpc = writeTo(busSel, busWrite, busAddr, OFF_PPCTRL);
   assign wrUnlock = writeTo(busSel, busWrite, busAddr, OFF_UNLOCK);
   assign wrIenw = writeTo(busSel, busWrite, busAddr, OFF_IENW);
   assign wrIdisw = writeTo(busSel, busWrite, busAddr, OFF_IDISW);
   assign wrIclr = writeTo(busSel, busWrite, busAddr, OFF_ICLR);

   // a protected write passes only right after a matching unlock
   assign protectedOk = unlockArmed_q && (unlockAddr_q == busAddr);
   assign accessError = wrPpc && !protectedOk;

   // the unlock holds for exactly the next bus access, read or write
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         unlockArmed_q <= 1'b0;
         unlockAddr_q <= '0;
      end else if (busSel) begin
         unlockArmed_q <= wrUnlock &&
            (busWdata[KEY_LSB +: 8] == UNLOCK_KEY);
         if (wrUnlock) begin
            unlockAddr_q <= busWdata[ADDR_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // peripheral power control
   // ---------------------------------------------------------------

   // stored only when the unlock sequence was kept
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ppc_q <= PPC_RESET;
      end else if (wrPpc && protectedOk) begin
         ppc_q <= busWdata[PPC_W-1:0];
      end
   end

   // control outputs straight from the register bits, the pull-up output inverted
   assign resetPinTestMode = ppc_q[PPC_TEST_MODE];
   assign forceSlowRcOutput = ppc_q[PPC_FORCE_RC];
   assign resetPinPullupOn = !ppc_q[PPC_PULLUP_OFF];
   assign touchRequestClockGate = ppc_q[PPC_GATE_LSB];
   assign comparatorRequestClockGate = ppc_q[PPC_GATE_LSB+1];
   assign adcRequestClockGate = ppc_q[PPC_GATE_LSB+2];
   assign asyncTimerRequestClockGate = ppc_q[PPC_GATE_LSB+3];
   assign twowireSlave0RequestClockGate = ppc_q[PPC_GATE_LSB+4];
   assign twowireSlave1RequestClockGate = ppc_q[PPC_GATE_LSB+5];

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------

   // access error is sticky; a new error wins over its clear
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         accErr_q <= 1'b0;
      end else if (accessError) begin
         accErr_q <= 1'b1;
      end else if (wrIclr && busWdata[BIT_ACCERR]) begin
         accErr_q <= 1'b0;
      end
   end

   // settled drops on a clock select write, a new write beats done
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         settled_q <= STATUS_RESET[BIT_SETTLED];
      end else if (clockSelectWritten) begin
         settled_q <= 1'b0;
      end else if (clocksAtNewRate) begin
         settled_q <= 1'b1;
      end
   end

   // failure latches until reset; the main clock stays on the rc
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         clkFail_q <= 1'b0;
      end else if (stable_q[0]) begin
         clkFail_q <= 1'b1;
      end
   end

   assign useInternalSystemRcOsc = clkFail_q;

   // assembled status word, reserved bits zero
   always_comb begin
      status = '0;
      status[BIT_ACCERR] = accErr_q;
      status[BIT_SETTLED] = settled_q;
      status[BIT_CLKFAIL] = clkFail_q;
   end

   // ---------------------------------------------------------------
   // interrupt mask and pending
   // ---------------------------------------------------------------

   // previous status for edge detection
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         statusPrev_q <= STATUS_RESET;
      end else begin
         statusPrev_q <= status;
      end
   end

   // one mask and one pending bit per event position
   generate
      for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_event
         localparam int P = (e == 0) ? BIT_CLKFAIL :
            (e == 1) ? BIT_SETTLED : BIT_ACCERR;

         // enable sets, disable clears
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               mask_q[P] <= 1'b0;
            end else if (wrIenw && busWdata[P]) begin
               mask_q[P] <= 1'b1;
            end else if (wrIdisw && busWdata[P]) begin
               mask_q[P] <= 1'b0;
            end
         end

         // rising flag sets and wins over a clear in the same cycle
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               pend_q[P] <= 1'b0;
            end else if (status[P] && !statusPrev_q[P]) begin
               pend_q[P] <= 1'b1;
            end else if (wrIclr && busWdata[P]) begin
               pend_q[P] <= 1'b0;
            end
         end
      end
   endgenerate

   // unused positions hold zero
   generate
      for (genvar b = 0; b < DATA_W; b++) begin : g_unused
         if (b != BIT_CLKFAIL && b != BIT_SETTLED && b != BIT_ACCERR)
         begin : g_zero
            assign mask_q[b] = 1'b0;
            assign pend_q[b] = 1'b0;
         end
      end
   endgenerate

   // request while any pending bit is enabled
   assign interruptRequest = |(pend_q & mask_q);

   // ---------------------------------------------------------------
   // reset source capture
   // ---------------------------------------------------------------

   // one-hot of the latest source, power-on highest priority
   always_comb begin
      rstOneHot = '0;
      if (stable_q[1] || stable_q[2] || stable_q[3]) begin
         rstOneHot[RS_POWER_ON] = 1'b1;
      end else if (stable_q[4]) begin
         rstOneHot[RS_BROWNOUT] = 1'b1;
      end else if (stable_q[5]) begin
         rstOneHot[RS_EXT_PIN] = 1'b1;
      end else if (stable_q[6]) begin
         rstOneHot[RS_WATCHDOG] = 1'b1;
      end else if (stable_q[7]) begin
         rstOneHot[RS_SHUTDOWN] = 1'b1;
      end else if (stable_q[8]) begin
         rstOneHot[RS_DEBUG_REQ] = 1'b1;
      end else if (stable_q[9]) begin
         rstOneHot[RS_JTAG] = 1'b1;
      end else if (stable_q[10]) begin
         rstOneHot[RS_SINGLE_PIN] = 1'b1;
      end
   end

   // wait for the synchronisers to settle, then load once
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         captureCnt_q <= '0;
         captured_q <= 1'b0;
         rstSrc_q <= '0;
      end else if (!captured_q) begin
         if (captureCnt_q == 3'(SYNC_STAGES + 1)) begin
            captured_q <= 1'b1;
            rstSrc_q <= rstOneHot;
         end else begin
            captureCnt_q <= captureCnt_q + 3'd1;
         end
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------

   // unmapped and write-only offsets read zero
   always_comb begin
      unique case (busAddr)
         OFF_PPCTRL: readMux = {{(DATA_W-PPC_W){1'b0}}, ppc_q};
         OFF_IMASK: readMux = mask_q;
         OFF_IPEND: readMux = pend_q;
         OFF_STATUS: readMux = status;
         OFF_RSTSRC: readMux = rstSrc_q;
         default: readMux = '0;
      endcase
   end

   // answer one cycle after every selected access
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         busRdata <= '0;
         busReady <= 1'b0;
      end else begin
         busReady <= busSel;
         if (busSel && !busWrite) begin
            busRdata <= readMux;
         end
      end
   end

endmodule // power_manager_status_irq_regs

// ---- inc/pm_regs_pkg.sv ----
/*
 * constants of the power manager status, interrupt and reset-cause
 * register group: offsets, field positions, reset values and keys.
 * assumes a 10-bit byte address on the peripheral bus and 32-bit data.
 */
package pm_regs_pkg;

   // ---------------------------------------------------------------
   // bus shape
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [9:0] OFF_PPCTRL = 10'h004;
   localparam logic [9:0] OFF_UNLOCK = 10'h058;
   localparam logic [9:0] OFF_IENW = 10'h0C0;
   localparam logic [9:0] OFF_IDISW = 10'h0C4;
   localparam logic [9:0] OFF_IMASK = 10'h0C8;
   localparam logic [9:0] OFF_IPEND = 10'h0CC;
   localparam logic [9:0] OFF_ICLR = 10'h0D0;
   localparam logic [9:0] OFF_STATUS = 10'h0D4;
   localparam logic [9:0] OFF_RSTSRC = 10'h180;

   // ---------------------------------------------------------------
   // unlock register fields
   // ---------------------------------------------------------------
   localparam logic [7:0] UNLOCK_KEY = 8'hAA;
   localparam int KEY_LSB = 24;

   // ---------------------------------------------------------------
   // status, mask and pending bit positions
   // ---------------------------------------------------------------
   localparam int BIT_CLKFAIL = 0;
   localparam int BIT_SETTLED = 5;
   localparam int BIT_ACCERR = 31;
   localparam int NUM_EVENTS = 3;

   // ---------------------------------------------------------------
   // peripheral power control fields
   // ---------------------------------------------------------------
   localparam int PPC_W = 9;
   localparam int PPC_PULLUP_OFF = 0;
   localparam int PPC_FORCE_RC = 1;
   localparam int PPC_TEST_MODE = 2;
   localparam int PPC_GATE_LSB = 3;
   localparam int NUM_GATES = 6;
   localparam logic [8:0] PPC_RESET = 9'h1FA;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0020;

   // ---------------------------------------------------------------
   // reset source bit positions
   // ---------------------------------------------------------------
   localparam int RS_POWER_ON = 0;
   localparam int RS_BROWNOUT = 1;
   localparam int RS_EXT_PIN = 2;
   localparam int RS_WATCHDOG = 3;
   localparam int RS_SHUTDOWN = 6;
   localparam int RS_DEBUG_REQ = 8;
   localparam int RS_JTAG = 9;
   localparam int RS_SINGLE_PIN = 12;

   // ---------------------------------------------------------------
   // input synchroniser depth
   // ---------------------------------------------------------------
   localparam int SYNC_STAGES = 3;
   localparam int NUM_ASYNC = 11;

endpackage : pm_regs_pkg

// ---- test/power_manager_status_irq_regs_assertions.sv ----
/* port checker of the power manager register group.
   assumes the top module's port names and the shared package. */
`timescale 1ns/100ps
module pm_regs_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic busSel,
   input wire logic busWrite,
   input wire logic [pm_regs_pkg::ADDR_W-1:0] busAddr,
   input wire logic [pm_regs_pkg::DATA_W-1:0] busWdata,
   input wire logic [pm_regs_pkg::DATA_W-1:0] busRdata,
   input wire logic busReady,
   input wire logic mainClockFailDetect,
   input wire logic useInternalSystemRcOsc,
   input wire logic resetPinTestMode,
   input wire logic forceSlowRcOutput,
   input wire logic resetPinPullupOn,
   input wire logic touchRequestClockGate,
   input wire logic comparatorRequestClockGate,
   input wire logic adcRequestClockGate,
   input wire logic asyncTimerRequestClockGate,
   input wire logic twowireSlave0RequestClockGate,
   input wire logic twowireSlave1RequestClockGate
);
   import pm_regs_pkg::*;
   // ----
   // control outputs and access shapes
   // ----
   logic [5:0] gates;
   assign gates = {twowireSlave1RequestClockGate,
      twowireSlave0RequestClockGate, asyncTimerRequestClockGate,
      adcRequestClockGate, comparatorRequestClockGate,
      touchRequestClockGate};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // key write straight followed by the protected write
   sequence unlockedWrite;
      busSel && busWrite && busAddr == OFF_UNLOCK
         && busWdata == {UNLOCK_KEY, 14'h0, OFF_PPCTRL}
      ##1 busSel && busWrite && busAddr == OFF_PPCTRL;
   endsequence
   // protected write with no key write just before it
   sequence bareWrite;
      !(busSel && busWrite && busAddr == OFF_UNLOCK)
      ##1 busSel && busWrite && busAddr == OFF_PPCTRL;
   endsequence
   // ----
   // assertions
   // ----
   chk_ready_pulse: assert property (busSel |=> busReady)
      else $error("ready missing after access");
   chk_ready_idle: assert property (!busSel |=> !busReady)
      else $error("ready without access");
   chk_rdata_hold: assert property
      (!(busSel && !busWrite) |=> $stable(busRdata))
      else $error("read data moved without read");
   chk_locked_write: assert property
      (bareWrite |=> $stable({gates, resetPinTestMode,
         forceSlowRcOutput, resetPinPullupOn}))
      else $error("locked write changed control");
   chk_test_mode: assert property (unlockedWrite |=>
      resetPinTestMode == $past(busWdata[PPC_TEST_MODE]))
      else $error("test mode output wrong");
   chk_force_rc: assert property (unlockedWrite |=>
      forceSlowRcOutput == $past(busWdata[PPC_FORCE_RC]))
      else $error("force output wrong");
   chk_pullup_pin: assert property (unlockedWrite |=>
      resetPinPullupOn == !$past(busWdata[PPC_PULLUP_OFF]))
      else $error("pull-up output wrong");
   chk_req_gates: assert property (unlockedWrite |=>
      gates == $past(busWdata[8:3]))
      else $error("request clock gates wrong");
   chk_rc_switch: assert property
      ($rose(mainClockFailDetect) |-> ##[1:8] useInternalSystemRcOsc)
      else $error("no switch to rc oscillator");
   chk_rc_sticky: assert property
      (useInternalSystemRcOsc |=> useInternalSystemRcOsc)
      else $error("rc select dropped");
endmodule // pm_regs_checker

bind power_manager_status_irq_regs pm_regs_checker u_pm_regs_checker (
   .ref_clk(ref_clk), .reset(reset), .busSel(busSel),
   .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
   .busRdata(busRdata), .busReady(busReady),
   .mainClockFailDetect(mainClockFailDetect),
   .useInternalSystemRcOsc(useInternalSystemRcOsc),
   .resetPinTestMode(resetPinTestMode),
   .forceSlowRcOutput(forceSlowRcOutput),
   .resetPinPullupOn(resetPinPullupOn),
   .touchRequestClockGate(touchRequestClockGate),
   .comparatorRequestClockGate(comparatorRequestClockGate),
   .adcRequestClockGate(adcRequestClockGate),
   .asyncTimerRequestClockGate(asyncTimerRequestClockGate),
   .twowireSlave0RequestClockGate(twowireSlave0RequestClockGate),
   .twowireSlave1RequestClockGate(twowireSlave1RequestClockGate));

// ---- test/testbench.sv ----
/* self-checking bench of the power manager register group.
   assumes the design package, the design and the bound checker. */
`timescale 1ns/100ps
module testbench;
   import pm_regs_pkg::*;
   // ----
   // signals
   // ----
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic busSel = 1'b0;
   logic busWrite = 1'b0;
   logic [9:0] busAddr = 10'h000;
   logic [31:0] busWdata = 32'h0;
   logic [31:0] busRdata;
   logic busReady;
   logic selWritten = 1'b0;
   logic newRate = 1'b0;
   logic clkFail = 1'b0;
   logic [9:0] srcLevel = 10'h001;
   logic irq, useRc, testMode, forceRc, pullupOn;
   logic [5:0] gates;
   logic [31:0] rdv, mask, val, ppcPins;
   int errCount = 0;
   int checksDone = 0;
   int cycles = 0;
   int seed = 32'h600e6060;
   int srcBit [10] = '{0, 0, 0, 1, 2, 3, 6, 8, 9, 12};
   assign ppcPins = {23'h0, gates, testMode, forceRc, ~pullupOn};
   power_manager_status_irq_regs u_power_manager_status_irq_regs (
      .ref_clk(ref_clk), .reset(reset), .busSel(busSel),
      .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
      .busRdata(busRdata), .busReady(busReady),
      .clockSelectWritten(selWritten), .clocksAtNewRate(newRate),
      .mainClockFailDetect(clkFail),
      .corePowerOnDetector(srcLevel[0]),
      .regulatorPowerOnDetector(srcLevel[1]),
      .regulatorInputMonitor(srcLevel[2]), .brownoutDetect(srcLevel[3]),
      .externalPinReset(srcLevel[4]), .watchdogReset(srcLevel[5]),
      .shutdownWakeReset(srcLevel[6]), .debugRequestReset(srcLevel[7]),
      .jtagReset(srcLevel[8]), .singlePinDebugReset(srcLevel[9]),
      .interruptRequest(irq), .useInternalSystemRcOsc(useRc),
      .resetPinTestMode(testMode), .forceSlowRcOutput(forceRc),
      .resetPinPullupOn(pullupOn), .touchRequestClockGate(gates[0]),
      .comparatorRequestClockGate(gates[1]),
      .adcRequestClockGate(gates[2]),
      .asyncTimerRequestClockGate(gates[3]),
      .twowireSlave0RequestClockGate(gates[4]),
      .twowireSlave1RequestClockGate(gates[5]));
   // ----
   // clock, watchdog on run length
   // ----
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 5000) begin
         errCount++;
         closeOut();
      end
   end
   // ----
   // helpers
   // ----
   task automatic closeOut();
      if (errCount == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus access; keep holds the select for a chained access
   task automatic acc(input logic wr, input logic [9:0] a,
         input logic [31:0] d, input logic keep);
      if (!busSel)
         @(negedge ref_clk);
      busSel = 1'b1;
      busWrite = wr;
      busAddr = a;
      busWdata = d;
      @(negedge ref_clk);
      check({31'h0, busReady}, 32'h1);
      rdv = busRdata;
      if (!keep)
         busSel = 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 1'b0);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, 1'b0);
      check(rdv, e);
   endtask
   task automatic ppcWrite(input logic [31:0] d);
      acc(1'b1, OFF_UNLOCK, {UNLOCK_KEY, 14'h0, OFF_PPCTRL}, 1'b1);
      acc(1'b1, OFF_PPCTRL, d, 1'b0);
   endtask
   // one-cycle pulse on a clock manager strobe
   task automatic pulse(input logic rate);
      @(negedge ref_clk);
      if (rate)
         newRate = 1'b1;
      else
         selWritten = 1'b1;
      @(negedge ref_clk);
      newRate = 1'b0;
      selWritten = 1'b0;
   endtask
   task automatic doReset(input logic [9:0] lv);
      srcLevel = lv;
      reset = 1'b1;
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      repeat (6) @(negedge ref_clk);
   endtask
   // highest ranked active source gives the only set bit
   function automatic logic [31:0] srcExp(input logic [9:0] lv);
      for (int i = 0; i < 10; i++)
         if (lv[i])
            return 32'h1 << srcBit[i];
      return 32'h0;
   endfunction
   // ----
   // main sequence
   // ----
   initial begin
      for (int i = 0; i < 14; i++) begin
         val = (i < 10) ? 32'h1 << i : $random(seed) | 32'h200;
         doReset(val[9:0]);
         rd(OFF_RSTSRC, srcExp(val[9:0]));
      end
      doReset(10'h001);
      rd(OFF_STATUS, 32'h20);
      rd(OFF_PPCTRL, 32'h1FA);
      check(ppcPins, 32'h1FA);
      wr(OFF_IMASK, 32'hFFFFFFFF);
      rd(OFF_IMASK, 32'h0);
      wr(10'h3F0, $random(seed));
      rd(10'h3F0, 32'h0);
      mask = 32'h0;
      for (int i = 0; i < 8; i++) begin
         val = $random(seed) & 32'h8000_0021;
         if (i[0]) begin
            wr(OFF_IDISW, val);
            mask = mask & ~val;
         end else begin
            wr(OFF_IENW, val);
            mask = mask | val;
         end
         rd(OFF_IMASK, mask);
      end
      wr(OFF_IENW, 32'h8000_0021);
      pulse(1'b0);
      rd(OFF_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
      pulse(1'b1);
      rd(OFF_STATUS, 32'h20);
      rd(OFF_IPEND, 32'h20);
      check({31'h0, irq}, 32'h1);
      wr(OFF_IDISW, 32'h20);
      check({31'h0, irq}, 32'h0);
      wr(OFF_IENW, 32'h20);
      wr(OFF_ICLR, 32'h0);
      rd(OFF_IPEND, 32'h20);
      wr(OFF_ICLR, 32'h20);
      rd(OFF_IPEND, 32'h0);
      check({31'h0, irq}, 32'h0);
      // key write cancelled by a read in between
      acc(1'b1, OFF_UNLOCK, {UNLOCK_KEY, 14'h0, OFF_PPCTRL}, 1'b1);
      acc(1'b0, OFF_STATUS, 32'h0, 1'b1);
      acc(1'b1, OFF_PPCTRL, 32'h0, 1'b0);
      rd(OFF_PPCTRL, 32'h1FA);
      rd(OFF_STATUS, 32'h8000_0020);
      rd(OFF_IPEND, 32'h8000_0000);
      check({31'h0, irq}, 32'h1);
      wr(OFF_ICLR, 32'h8000_0000);
      rd(OFF_IPEND, 32'h0);
      for (int i = 0; i < 6; i++) begin
         val = (i < 2) ? {23'h0, {9{i[0]}}} : $random(seed);
         ppcWrite(val);
         check(ppcPins, {23'h0, val[8:0]});
         rd(OFF_PPCTRL, {23'h0, val[8:0]});
      end
      rd(OFF_STATUS, 32'h20);
      clkFail = 1'b1;
      repeat (8) @(negedge ref_clk);
      check({31'h0, useRc}, 32'h1);
      rd(OFF_STATUS, 32'h21);
      rd(OFF_IPEND, 32'h1);
      check({31'h0, irq}, 32'h1);
      closeOut();
   end
endmodule // testbench
